// *** include/phyrx_defs.svh ***
// Offsets, field positions, reset values and timing counts for the receive path registers.
`ifndef PHYRX_DEFS_SVH
`define PHYRX_DEFS_SVH

// ----------------------------------------------------------------------------
// Register indexes; the byte address is four times the index.
// ----------------------------------------------------------------------------
`define PHYRX_IDX_FECFG 10'h043
`define PHYRX_IDX_VTM 10'h053
`define PHYRX_IDX_SKEW 10'h055
`define PHYRX_IDX_STRAP 10'h06e

// ----------------------------------------------------------------------------
// Field positions of fast_ethernet_rx_config.
// ----------------------------------------------------------------------------
`define PHYRX_FE_ABORT_DIS 11
`define PHYRX_FE_RECOV_MSB 10
`define PHYRX_FE_RECOV_LSB 7
`define PHYRX_FE_FORCE_LINK 6
`define PHYRX_FE_ETD 5
`define PHYRX_FE_EGD 4
`define PHYRX_FE_SKIP 3
`define PHYRX_FE_SCR_OFF 2
`define PHYRX_FE_ODD 1
`define PHYRX_FE_EARLY 0

// ----------------------------------------------------------------------------
// Reset values and fixed read-only contents.
// ----------------------------------------------------------------------------
`define PHYRX_FE_RESET 16'h07a0
`define PHYRX_FE_WMASK 16'h0fff
`define PHYRX_VTM_RSVD 12'h205
`define PHYRX_VTM_THR_RESET 4'h5
`define PHYRX_SKEW_RESET 8'h00

// ----------------------------------------------------------------------------
// Timing: clock period, descrambler timeout and millisecond length.
// ----------------------------------------------------------------------------
`define PHYRX_CLK_PERIOD_NS 20
`define PHYRX_DESCR_TIMEOUT_US 1500
`define PHYRX_MS_NS 1000000
`define PHYRX_DESCR_TIMEOUT_CYC (`PHYRX_DESCR_TIMEOUT_US * 1000 / `PHYRX_CLK_PERIOD_NS)
`define PHYRX_MS_CYC (`PHYRX_MS_NS / `PHYRX_CLK_PERIOD_NS)

`endif

// *** include/phyrx_pkg.sv ***
// Types shared by the receive path register block.
package phyrx_pkg;

  // Register selected by an APB address.
  typedef enum logic [2:0] {
    PHYRX_SEL_NONE,
    PHYRX_SEL_FECFG,
    PHYRX_SEL_VTM,
    PHYRX_SEL_SKEW,
    PHYRX_SEL_STRAP
  } phyrx_sel_type;

  // Descrambler lock recovery states.
  typedef enum {
    PHYRX_RC_LOCKED,
    PHYRX_RC_RECOVER
  } phyrx_recov_type;

endpackage

// *** src/phyrx_tick.sv ***
// Periodic one-cycle enable pulse generator with restart.
`timescale 1ns/1ps
`default_nettype none

module phyrx_tick #(
  parameter int PERIOD = 50000
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Control.
  input wire logic restart,
  // Output pulse.
  output logic tick
);

  localparam int W = $clog2(PERIOD + 1);

  logic [W-1:0] cnt_q;

  // A period of one would make the pulse a steady level.
  if (PERIOD < 2) begin : g_chk
    $error("phyrx_tick: PERIOD must be at least 2");
  end

  // Count up to the period; restart realigns so that a full period follows.
  always_ff @(posedge clk) begin
    if (rst || restart) begin
      cnt_q <= '0;
    end else if (cnt_q == W'(PERIOD - 1)) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + W'(1);
    end
  end

  // Pulse on the last cycle of each period.
  assign tick = !rst && !restart && (cnt_q == W'(PERIOD - 1));

endmodule

`default_nettype wire

// *** src/phyrx_regs.sv ***
// Receive path configuration and status registers with their control logic.
`timescale 1ns/1ps
`default_nettype none
`include "phyrx_defs.svh"

// Function
// - Packet over 1.5 ms aborted unless disabled.
// - Unlock recovery time in milliseconds, default 15.
// - Force bit reports good 100 Mbit/s link.
// - Enhanced ternary detection enabled out of reset.
// - Enable bit selects enhanced gap detection.
// - Bypass bit skips the block decoder.
// - Scrambler off bit disables scrambling.
// - Odd nibble packets detected when enabled.
// - Early receive valid bit advances RX_DV.
// - Idle mode after threshold consecutive idles.
// - Channel skews readable, reset to zero.
module phyrx_regs
  import phyrx_pkg::*;
#(
  parameter int DESCR_TIMEOUT_CYC = `PHYRX_DESCR_TIMEOUT_CYC,
  parameter int MS_CYC = `PHYRX_MS_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // APB slave.
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receive path status from the datapath.
  input wire logic rx_pkt_active,
  input wire logic nibble_valid,
  input wire logic descr_unlock,
  input wire logic link_qualified,
  input wire logic sym_valid,
  input wire logic sym_is_idle,
  input wire logic [3:0] first_channel_skew,
  input wire logic [3:0] second_channel_skew,
  input wire logic [15:0] strap_pins,
  // Controls to the datapath.
  output logic rx_abort,
  output logic descr_recovering,
  output logic link_good_100,
  output logic enhanced_ternary_detect_en,
  output logic enhanced_gap_detect_en,
  output logic rx_block_decoder_skip,
  output logic scrambling_off,
  output logic early_rx_valid_en,
  output logic odd_nibble_event,
  output logic idle_mode
);

  localparam int TW = $clog2(DESCR_TIMEOUT_CYC + 1);

  // --------------------------------------------------------------------------
  // Parameter checks.
  // --------------------------------------------------------------------------
  if (DESCR_TIMEOUT_CYC < 2) begin : g_chk_tmo
    $error("phyrx_regs: DESCR_TIMEOUT_CYC must be at least 2");
  end
  if (MS_CYC < 2) begin : g_chk_ms
    $error("phyrx_regs: MS_CYC must be at least 2");
  end

  // --------------------------------------------------------------------------
  // Storage.
  // --------------------------------------------------------------------------
  logic [15:0] fe_q;
  logic [3:0] thr_q;
  logic [7:0] skew_q;
  logic [15:0] strap_q;
  logic strap_taken_q;
  logic [TW-1:0] tmo_cnt_q;
  logic abort_q;
  phyrx_recov_type rc_state_q;
  logic [3:0] recov_cnt_q;
  logic ms_tick;
  logic parity_q;
  logic pkt_q;
  logic odd_q;
  logic [3:0] idle_cnt_q;
  logic idle_q;
  logic link_q;
  logic [31:0] prdata_q;
  phyrx_sel_type sel;
  logic wr_en;
  logic rd_setup;

  // Address decode; misaligned and unknown offsets select nothing.
  function automatic phyrx_sel_type phyrx_decode(input logic [11:0] a);
    phyrx_sel_type s;
    s = PHYRX_SEL_NONE;
    if (a[1:0] == 2'b00) begin
      case (a[11:2])
        `PHYRX_IDX_FECFG: s = PHYRX_SEL_FECFG;
        `PHYRX_IDX_VTM: s = PHYRX_SEL_VTM;
        `PHYRX_IDX_SKEW: s = PHYRX_SEL_SKEW;
        `PHYRX_IDX_STRAP: s = PHYRX_SEL_STRAP;
        default: s = PHYRX_SEL_NONE;
      endcase
    end
    return s;
  endfunction

  // --------------------------------------------------------------------------
  // APB slave.
  // --------------------------------------------------------------------------
  // Zero wait states: read data is latched in the setup cycle.
  assign sel = phyrx_decode(paddr);
  assign pready = 1'b1;
  assign pslverr = psel && penable && (sel == PHYRX_SEL_NONE);
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign prdata = prdata_q;

  // Read mux; reserved bits return their fixed contents.
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_setup) begin
      case (sel)
        PHYRX_SEL_FECFG: prdata_q <= {16'h0000, fe_q};
        PHYRX_SEL_VTM: prdata_q <= {16'h0000, `PHYRX_VTM_RSVD, thr_q};
        PHYRX_SEL_SKEW: prdata_q <= {24'h00_0000, skew_q};
        PHYRX_SEL_STRAP: prdata_q <= {16'h0000, strap_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Configuration write; the mask keeps bits 15:12 at zero.
  always_ff @(posedge clk) begin
    if (rst) begin
      fe_q <= `PHYRX_FE_RESET;
    end else if (wr_en && sel == PHYRX_SEL_FECFG) begin
      if (pstrb[0]) begin
        fe_q[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        fe_q[15:8] <= pwdata[15:8] & 8'(`PHYRX_FE_WMASK >> 8);
      end
    end
  end

  // Idle threshold; only the low nibble is writable.
  always_ff @(posedge clk) begin
    if (rst) begin
      thr_q <= `PHYRX_VTM_THR_RESET;
    end else if (wr_en && sel == PHYRX_SEL_VTM && pstrb[0]) begin
      thr_q <= pwdata[3:0];
    end
  end

  // Skew is sampled every cycle so a read shows the latest alignment.
  always_ff @(posedge clk) begin
    if (rst) begin
      skew_q <= `PHYRX_SKEW_RESET;
    end else begin
      skew_q <= {second_channel_skew, first_channel_skew};
    end
  end

  // Straps are caught once, in the first cycle after reset release.
  always_ff @(posedge clk) begin
    if (rst) begin
      strap_q <= 16'h0000;
      strap_taken_q <= 1'b0;
    end else if (!strap_taken_q) begin
      strap_q <= strap_pins;
      strap_taken_q <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Static controls straight from the configuration flops.
  // --------------------------------------------------------------------------
  assign enhanced_ternary_detect_en = fe_q[`PHYRX_FE_ETD];
  assign enhanced_gap_detect_en = fe_q[`PHYRX_FE_EGD];
  assign rx_block_decoder_skip = fe_q[`PHYRX_FE_SKIP];
  assign scrambling_off = fe_q[`PHYRX_FE_SCR_OFF];
  assign early_rx_valid_en = fe_q[`PHYRX_FE_EARLY];

  // Link report; the override hides a failing qualifier.
  always_ff @(posedge clk) begin
    if (rst) begin
      link_q <= 1'b0;
    end else begin
      link_q <= fe_q[`PHYRX_FE_FORCE_LINK] || link_qualified;
    end
  end
  assign link_good_100 = link_q;

  // --------------------------------------------------------------------------
  // Descrambler timeout on long packets.
  // --------------------------------------------------------------------------
  // The counter saturates so a very long packet cannot wrap and re-arm.
  always_ff @(posedge clk) begin
    if (rst || !rx_pkt_active) begin
      tmo_cnt_q <= '0;
    end else if (tmo_cnt_q != TW'(DESCR_TIMEOUT_CYC)) begin
      tmo_cnt_q <= tmo_cnt_q + TW'(1);
    end
  end

  // Abort holds until the packet ends.
  always_ff @(posedge clk) begin
    if (rst || !rx_pkt_active) begin
      abort_q <= 1'b0;
    end else if (tmo_cnt_q == TW'(DESCR_TIMEOUT_CYC - 1) &&
                 !fe_q[`PHYRX_FE_ABORT_DIS]) begin
      abort_q <= 1'b1;
    end
  end
  assign rx_abort = abort_q;

  // --------------------------------------------------------------------------
  // Recovery after descrambler unlock.
  // --------------------------------------------------------------------------
  phyrx_tick #(
    .PERIOD(MS_CYC)
  ) u_ms_tick (
    .clk(clk),
    .rst(rst),
    .restart(descr_unlock),
    .tick(ms_tick)
  );

  // A fresh unlock during recovery reloads the full time.
  always_ff @(posedge clk) begin
    if (rst) begin
      rc_state_q <= PHYRX_RC_LOCKED;
      recov_cnt_q <= 4'h0;
    end else begin
      case (rc_state_q)
        PHYRX_RC_LOCKED: begin
          if (descr_unlock) begin
            recov_cnt_q <= fe_q[`PHYRX_FE_RECOV_MSB:`PHYRX_FE_RECOV_LSB];
            rc_state_q <= PHYRX_RC_RECOVER;
          end
        end
        PHYRX_RC_RECOVER: begin
          if (descr_unlock) begin
            recov_cnt_q <= fe_q[`PHYRX_FE_RECOV_MSB:`PHYRX_FE_RECOV_LSB];
          end else if (recov_cnt_q == 4'h0) begin
            rc_state_q <= PHYRX_RC_LOCKED;
          end else if (ms_tick) begin
            recov_cnt_q <= recov_cnt_q - 4'h1;
          end
        end
        default: begin
          rc_state_q <= PHYRX_RC_LOCKED;
        end
      endcase
    end
  end
  assign descr_recovering = (rc_state_q == PHYRX_RC_RECOVER);

  // --------------------------------------------------------------------------
  // Odd nibble detection.
  // --------------------------------------------------------------------------
  // Parity restarts with each packet; the check fires at its end.
  always_ff @(posedge clk) begin
    if (rst) begin
      parity_q <= 1'b0;
      pkt_q <= 1'b0;
      odd_q <= 1'b0;
    end else begin
      pkt_q <= rx_pkt_active;
      odd_q <= pkt_q && !rx_pkt_active && parity_q &&
               fe_q[`PHYRX_FE_ODD];
      if (!pkt_q && rx_pkt_active) begin
        parity_q <= nibble_valid;
      end else if (rx_pkt_active && nibble_valid) begin
        parity_q <= !parity_q;
      end
    end
  end
  assign odd_nibble_event = odd_q;

  // --------------------------------------------------------------------------
  // Idle symbol detector.
  // --------------------------------------------------------------------------
  // The count saturates at fifteen; any non-idle symbol restarts it.
  always_ff @(posedge clk) begin
    if (rst) begin
      idle_cnt_q <= 4'h0;
      idle_q <= 1'b0;
    end else if (sym_valid) begin
      if (sym_is_idle) begin
        if (idle_cnt_q != 4'hf) begin
          idle_cnt_q <= idle_cnt_q + 4'h1;
        end
        if ({1'b0, idle_cnt_q} + 5'h01 >= {1'b0, thr_q}) begin
          idle_q <= 1'b1;
        end
      end else begin
        idle_cnt_q <= 4'h0;
        idle_q <= 1'b0;
      end
    end
  end
  assign idle_mode = idle_q;

  // --------------------------------------------------------------------------
  // Assertions.
  // --------------------------------------------------------------------------
  property p_abort_on_timeout;
    @(posedge clk) disable iff (rst)
      $rose(rx_abort) |->
        $past(tmo_cnt_q) == TW'(DESCR_TIMEOUT_CYC - 1) &&
        !$past(fe_q[`PHYRX_FE_ABORT_DIS]);
  endproperty
  a_abort_on_timeout: assert property (p_abort_on_timeout)
    else $error("abort raised without a timeout");

  property p_recovery_load;
    @(posedge clk) disable iff (rst)
      (descr_unlock && rc_state_q == PHYRX_RC_LOCKED) |=>
        descr_recovering &&
        recov_cnt_q == $past(fe_q[`PHYRX_FE_RECOV_MSB:`PHYRX_FE_RECOV_LSB]);
  endproperty
  a_recovery_load: assert property (p_recovery_load)
    else $error("recovery did not load the programmed time");

  property p_force_link;
    @(posedge clk) disable iff (rst)
      fe_q[`PHYRX_FE_FORCE_LINK] |=> link_good_100;
  endproperty
  a_force_link: assert property (p_force_link)
    else $error("forced link not reported good");

  property p_reset_values;
    @(posedge clk)
      $past(rst) |-> fe_q == `PHYRX_FE_RESET &&
        thr_q == `PHYRX_VTM_THR_RESET && enhanced_ternary_detect_en;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("wrong value after reset");

  property p_ctrl_write;
    @(posedge clk) disable iff (rst)
      (wr_en && sel == PHYRX_SEL_FECFG && pstrb[0]) |=>
        {enhanced_gap_detect_en, rx_block_decoder_skip, scrambling_off,
         early_rx_valid_en} ==
        {$past(pwdata[4]), $past(pwdata[3]), $past(pwdata[2]),
         $past(pwdata[0])};
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("control outputs do not follow the write");

  property p_odd_event;
    @(posedge clk) disable iff (rst)
      odd_nibble_event |-> $past(parity_q) && $past(fe_q[`PHYRX_FE_ODD]) &&
        $fell(pkt_q) && !$past(rx_pkt_active) ##1 !odd_nibble_event;
  endproperty
  a_odd_event: assert property (p_odd_event)
    else $error("odd nibble event without an odd packet");

  property p_idle_mode;
    @(posedge clk) disable iff (rst)
      $rose(idle_mode) |->
        $past(sym_valid && sym_is_idle) &&
        ({1'b0, $past(idle_cnt_q)} + 5'h01 >= {1'b0, $past(thr_q)});
  endproperty
  a_idle_mode: assert property (p_idle_mode)
    else $error("idle mode entered before the threshold");

  property p_skew_read;
    @(posedge clk) disable iff (rst)
      (rd_setup && sel == PHYRX_SEL_SKEW) |=>
        prdata[31:8] == 24'h00_0000 && prdata[7:0] == $past(skew_q);
  endproperty
  a_skew_read: assert property (p_skew_read)
    else $error("skew read returned wrong data");

  property p_vtm_rsvd;
    @(posedge clk) disable iff (rst)
      (rd_setup && sel == PHYRX_SEL_VTM) |=>
        prdata[31:4] == {16'h0000, `PHYRX_VTM_RSVD};
  endproperty
  a_vtm_rsvd: assert property (p_vtm_rsvd)
    else $error("reserved threshold bits not fixed");

  property p_fe_rsvd;
    @(posedge clk) disable iff (rst)
      fe_q[15:12] == 4'h0;
  endproperty
  a_fe_rsvd: assert property (p_fe_rsvd)
    else $error("reserved configuration bits written");

  // Main scenarios.
  property p_cov_abort;
    @(posedge clk) disable iff (rst) $rose(rx_abort);
  endproperty
  c_cov_abort: cover property (p_cov_abort);

  property p_cov_recover_done;
    @(posedge clk) disable iff (rst) $fell(descr_recovering);
  endproperty
  c_cov_recover_done: cover property (p_cov_recover_done);

  property p_cov_odd;
    @(posedge clk) disable iff (rst) odd_nibble_event;
  endproperty
  c_cov_odd: cover property (p_cov_odd);

  property p_cov_idle;
    @(posedge clk) disable iff (rst) $rose(idle_mode);
  endproperty
  c_cov_idle: cover property (p_cov_idle);

endmodule

`default_nettype wire

// *** verif/tb_phy_rx_path_config_regs.sv ***
// Self-checking testbench for the receive path configuration registers.
`timescale 1ns/1ps
`default_nettype none
`include "phyrx_defs.svh"

module tb_phy_rx_path_config_regs;
  import phyrx_pkg::*;

  // ---------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------
  localparam logic [11:0] A_FE = {`PHYRX_IDX_FECFG, 2'b00};
  localparam logic [11:0] A_VTM = {`PHYRX_IDX_VTM, 2'b00};
  localparam logic [11:0] A_SKEW = {`PHYRX_IDX_SKEW, 2'b00};
  localparam logic [11:0] A_STRAP = {`PHYRX_IDX_STRAP, 2'b00};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic rx_pkt_active = 1'b0;
  logic nibble_valid = 1'b0;
  logic descr_unlock = 1'b0;
  logic link_qualified = 1'b0;
  logic sym_valid = 1'b0;
  logic sym_is_idle = 1'b0;
  logic [3:0] skew_a = 4'h0;
  logic [3:0] skew_b = 4'h0;
  logic rx_abort, descr_recovering, link_good_100, idle_mode;
  logic ternary, gap, skip, scr_off, early, odd_evt;
  logic [31:0] rd;
  logic err;
  int n_mismatch = 0;
  int tests_run = 0;
  int n_odd = 0;
  int bit_pos [5] = '{5, 4, 3, 2, 0};

  // ---------------------------------------------------------------------
  // Design under test with shortened counts
  // ---------------------------------------------------------------------
  phyrx_regs #(.DESCR_TIMEOUT_CYC(20), .MS_CYC(10)) dut (
    .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_pkt_active(rx_pkt_active),
    .nibble_valid(nibble_valid), .descr_unlock(descr_unlock),
    .link_qualified(link_qualified), .sym_valid(sym_valid),
    .sym_is_idle(sym_is_idle), .first_channel_skew(skew_a),
    .second_channel_skew(skew_b), .strap_pins(16'h3c5a),
    .rx_abort(rx_abort), .descr_recovering(descr_recovering),
    .link_good_100(link_good_100), .enhanced_ternary_detect_en(ternary),
    .enhanced_gap_detect_en(gap), .rx_block_decoder_skip(skip),
    .scrambling_off(scr_off), .early_rx_valid_en(early),
    .odd_nibble_event(odd_evt), .idle_mode(idle_mode));

  // Free-running 50 MHz clock.
  always #10 clk = ~clk;

  // Odd nibble pulses are one cycle wide, so they are counted at each edge.
  always @(posedge clk) begin
    if (odd_evt === 1'b1) begin
      n_odd <= n_odd + 1;
    end
  end

  // ---------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------
  // Compares two values and counts the outcome.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request stands until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int w;
    w = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && w < 50) begin
      w++;
      @(posedge clk);
    end
    if (w >= 50) begin
      n_mismatch++;
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reads a register and compares data and error response.
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
                        input logic exp_err);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
    check(rd, exp);
    check({31'h0, err}, {31'h0, exp_err});
  endtask

  // Waits a number of edges and lets the design's updates land.
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Sends a packet holding the given number of nibbles.
  task automatic packet(input int nib);
    @(posedge clk);
    rx_pkt_active <= 1'b1;
    for (int i = 0; i < nib; i++) begin
      nibble_valid <= 1'b1;
      @(posedge clk);
      nibble_valid <= 1'b0;
      @(posedge clk);
    end
    rx_pkt_active <= 1'b0;
    step(6);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------
  // Watchdog: the tests need a few hundred cycles at most.
  // ---------------------------------------------------------------------
  initial begin
    #200000;
    n_mismatch++;
    give_verdict();
  end

  // ---------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    step(2);
    check({27'h0, ternary, gap, skip, scr_off, early}, 32'h0000_0010);
    rd_chk(A_FE, {16'h0, `PHYRX_FE_RESET}, 1'b0);
    rd_chk(A_VTM, {16'h0, `PHYRX_VTM_RSVD, `PHYRX_VTM_THR_RESET}, 1'b0);
    rd_chk(A_SKEW, 32'h0000_0000, 1'b0);
    rd_chk(A_STRAP, 32'h0000_3c5a, 1'b0);
    $display("test reset_values done");
    // Each control bit alone must reach only its own output.
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, A_FE, 32'h1 << bit_pos[i], 4'h3);
      step(1);
      check({27'h0, ternary, gap, skip, scr_off, early}, 32'h10 >> i);
    end
    apb(1'b1, A_FE, 32'hffff_ffff, 4'h3);
    rd_chk(A_FE, 32'h0000_0fff, 1'b0);
    apb(1'b1, A_FE, 32'h0000_0000, 4'h1);
    rd_chk(A_FE, 32'h0000_0f00, 1'b0);
    apb(1'b1, A_VTM, 32'h0000_fff4, 4'h3);
    rd_chk(A_VTM, {16'h0, `PHYRX_VTM_RSVD, 4'h4}, 1'b0);
    rd_chk(12'h000, 32'h0000_0000, 1'b1);
    rd_chk(A_FE + 12'h001, 32'h0000_0000, 1'b1);
    $display("test register_access done");
    skew_a <= 4'h9;
    skew_b <= 4'h6;
    step(3);
    rd_chk(A_SKEW, 32'h0000_0069, 1'b0);
    $display("test skew done");
    apb(1'b1, A_FE, 32'h0000_0040, 4'h3);
    step(2);
    check({31'h0, link_good_100}, 32'h1);
    apb(1'b1, A_FE, 32'h0000_0000, 4'h3);
    step(2);
    check({31'h0, link_good_100}, 32'h0);
    @(posedge clk);
    link_qualified <= 1'b1;
    step(2);
    check({31'h0, link_good_100}, 32'h1);
    $display("test force_link done");
    // Packet longer than the shortened timeout of twenty cycles.
    @(posedge clk);
    rx_pkt_active <= 1'b1;
    step(18);
    check({31'h0, rx_abort}, 32'h0);
    step(6);
    check({31'h0, rx_abort}, 32'h1);
    @(posedge clk);
    rx_pkt_active <= 1'b0;
    step(3);
    check({31'h0, rx_abort}, 32'h0);
    apb(1'b1, A_FE, 32'h0000_0800, 4'h3);
    rx_pkt_active <= 1'b1;
    step(30);
    check({31'h0, rx_abort}, 32'h0);
    @(posedge clk);
    rx_pkt_active <= 1'b0;
    $display("test abort done");
    // Recovery of two milliseconds, each ten cycles long here.
    apb(1'b1, A_FE, 32'h0000_0100, 4'h3);
    descr_unlock <= 1'b1;
    @(posedge clk);
    descr_unlock <= 1'b0;
    step(3);
    check({31'h0, descr_recovering}, 32'h1);
    step(12);
    check({31'h0, descr_recovering}, 32'h1);
    step(25);
    check({31'h0, descr_recovering}, 32'h0);
    $display("test recovery done");
    packet(3);
    check(n_odd, 32'h0);
    apb(1'b1, A_FE, 32'h0000_0002, 4'h3);
    packet(3);
    check(n_odd, 32'h1);
    packet(4);
    check(n_odd, 32'h1);
    $display("test odd_nibble done");
    // Threshold is four from the earlier write, then five again.
    @(posedge clk);
    sym_valid <= 1'b1;
    sym_is_idle <= 1'b1;
    step(3);
    check({31'h0, idle_mode}, 32'h0);
    step(2);
    check({31'h0, idle_mode}, 32'h1);
    @(posedge clk);
    sym_is_idle <= 1'b0;
    step(2);
    check({31'h0, idle_mode}, 32'h0);
    apb(1'b1, A_VTM, 32'h0000_0005, 4'h1);
    sym_is_idle <= 1'b1;
    step(4);
    check({31'h0, idle_mode}, 32'h0);
    step(2);
    check({31'h0, idle_mode}, 32'h1);
    @(posedge clk);
    sym_valid <= 1'b0;
    $display("test idle_detect done");
    give_verdict();
  end

endmodule
`default_nettype wire
